/* core/tmt_defs.svh */
// Offsets, field positions, reset values and sizes for the transition mask and display test registers.
// Assumes it is included by its bare name from the package and the modules.
`ifndef TMT_DEFS_SVH
`define TMT_DEFS_SVH

`define TMT_MASK_ADDR 8'h06
`define TMT_TEST_ADDR 8'h07
`define TMT_MASK_RESET 7'h00
`define TMT_TEST_RESET 1'b0
`define TMT_INT_BIT 7
`define TMT_TEST_BIT 0
`define TMT_WATCH_PORTS 7
`define TMT_SEGMENTS 28
`define TMT_CODE_W 4
`define TMT_LEVEL_W 5
`define TMT_DEV_ADDR 7'h40

`endif

/* core/tmt_pkg.sv */
// Types shared by the register slice and its port watcher.
// Assumes tmt_defs.svh is on the include path.
`default_nettype none
`include "tmt_defs.svh"

package tmt_pkg;

  // Serial byte engine phases
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } tmt_phase_e;

  // State of one watched port
  typedef struct packed {
    logic prev;
    logic primed;
  } tmt_watch_s;

  // State of the register slice
  typedef struct packed {
    tmt_phase_e phase;
    logic [2:0] bitCnt;
    logic got8;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic sclQ;
    logic sdaQ;
    logic sdaOe;
    logic [`TMT_WATCH_PORTS-1:0] mask;
    logic intFlag;
    logic testMode;
    logic [`TMT_SEGMENTS*`TMT_LEVEL_W-1:0] segLevel;
  } tmt_state_s;

endpackage : tmt_pkg

`default_nettype wire

/* core/tmt_port_watch.sv */
// One watched port: flags a change of logic level while watching is enabled.
// Assumes the port level is synchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module tmt_port_watch (
  input wire logic clock, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic level, // Port logic level
  input wire logic watch, // Mask bit for this port
  output logic changed // One-cycle pulse on a watched change
);

  tmt_pkg::tmt_watch_s s;
  tmt_pkg::tmt_watch_s next_s;

  // Primed bit stops the first sample after reset from looking like a change
  always_comb begin
    next_s = s;
    next_s.prev = level;
    next_s.primed = 1'b1;
  end

  // Register the copy
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Only ports whose mask bit is set may raise a change
  assign changed = s.primed & watch & (level != s.prev);

endmodule : tmt_port_watch

`default_nettype wire

/* core/tmt_regs.sv */
// Transition mask and display test register slice behind a two-wire serial slave.
// Assumes SCL and SDA are synchronous to clock and the bus wire is resolved outside from sdaOe.
`timescale 1ns/10ps
`default_nettype none
`include "tmt_defs.svh"

module tmt_regs (
  input wire logic clock, // 40 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic scl, // Serial clock level
  input wire logic sdaIn, // Serial data wire level
  output logic sdaOut, // Serial data drive value, always low
  output logic sdaOe, // High while pulling serial data low
  input wire logic [`TMT_WATCH_PORTS-1:0] portLevel, // Levels of port_24 .. port_30
  output logic intPending, // Transition interrupt flag, high while pending
  output logic [`TMT_WATCH_PORTS-1:0] portMask, // Mask bits for port_24 .. port_30
  output logic displayTest, // High in display test mode
  input wire logic [`TMT_SEGMENTS-1:0] segOn, // Segment drive enable
  input wire logic [`TMT_SEGMENTS*`TMT_CODE_W-1:0] segCode, // Segment current step code
  output logic [`TMT_SEGMENTS*`TMT_LEVEL_W-1:0] segLevel // Segment drive in sixteenths, 0 is off
);

  tmt_pkg::tmt_state_s s;
  tmt_pkg::tmt_state_s next_s;
  logic [`TMT_WATCH_PORTS-1:0] portChanged;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] readByte;

  // One watcher per maskable port
  genvar g;
  generate
    for (g = 0; g < `TMT_WATCH_PORTS; g = g + 1) begin : gWatch
      tmt_port_watch uWatch (
        .clock(clock),
        .arst_n(arst_n),
        .level(portLevel[g]),
        .watch(s.mask[g]),
        .changed(portChanged[g])
      );
    end
  endgenerate

  // Bus events from the previous samples
  assign sclRise = scl & ~s.sclQ;
  assign sclFall = ~scl & s.sclQ;
  assign startSeen = scl & s.sclQ & s.sdaQ & ~sdaIn;
  assign stopSeen = scl & s.sclQ & ~s.sdaQ & sdaIn;

  // Read data for the current pointer; unmapped addresses read zero
  always_comb begin
    readByte = 8'h00;
    if (s.ptr == `TMT_MASK_ADDR) begin
      readByte = {s.intFlag, s.mask};
    end else if (s.ptr == `TMT_TEST_ADDR) begin
      readByte = {7'h00, s.testMode};
    end
  end

  // Next state of the whole slice
  always_comb begin
    // High in the cycle a mask register byte is loaded for reading
    logic readClear;
    readClear = 1'b0;
    next_s = s;
    next_s.sclQ = scl;
    next_s.sdaQ = sdaIn;

    // Segment drive: off, or code plus one sixteenths
    for (int i = 0; i < `TMT_SEGMENTS; i++) begin
      next_s.segLevel[i*`TMT_LEVEL_W +: `TMT_LEVEL_W] = segOn[i] ?
        ({1'b0, segCode[i*`TMT_CODE_W +: `TMT_CODE_W]} + 5'h01) : 5'h00;
    end

    if (startSeen) begin
      // A repeated start may cut any phase short
      next_s.phase = tmt_pkg::ST_ADDR;
      next_s.bitCnt = 3'h0;
      next_s.got8 = 1'b0;
      next_s.sdaOe = 1'b0;
    end else if (stopSeen) begin
      // Stop only ends the frame; writes have already committed at their acknowledge
      next_s.phase = tmt_pkg::ST_IDLE;
      next_s.sdaOe = 1'b0;
      next_s.got8 = 1'b0;
    end else begin
      unique case (s.phase)
        // Wait for a start; a foreign address also parks here
        tmt_pkg::ST_IDLE: begin
          next_s.sdaOe = 1'b0;
        end
        // Take one byte MSB first, then pull SDA low for its acknowledge
        tmt_pkg::ST_ADDR, tmt_pkg::ST_PTR, tmt_pkg::ST_WDATA: begin
          if (sclRise) begin
            next_s.shift = {s.shift[6:0], sdaIn};
            next_s.bitCnt = s.bitCnt + 3'h1;
            next_s.got8 = (s.bitCnt == 3'h7);
          end else if (sclFall && s.got8) begin
            next_s.got8 = 1'b0;
            next_s.sdaOe = 1'b1;
            if (s.phase == tmt_pkg::ST_ADDR) begin
              if (s.shift[7:1] == `TMT_DEV_ADDR) begin
                next_s.rw = s.shift[0];
                next_s.phase = tmt_pkg::ST_ADDR_ACK;
              end else begin
                next_s.sdaOe = 1'b0;
                next_s.phase = tmt_pkg::ST_IDLE;
              end
            end else if (s.phase == tmt_pkg::ST_PTR) begin
              next_s.ptr = s.shift;
              next_s.phase = tmt_pkg::ST_PTR_ACK;
            end else begin
              next_s.phase = tmt_pkg::ST_WDATA_ACK;
            end
          end
        end
        // Pointer taken: let go of SDA and expect data or a repeated start
        tmt_pkg::ST_PTR_ACK: begin
          if (sclFall) begin
            next_s.sdaOe = 1'b0;
            next_s.phase = tmt_pkg::ST_WDATA;
          end
        end
        tmt_pkg::ST_WDATA_ACK: begin
          // Commit on the acknowledge clock's rising edge, not at stop
          if (sclRise) begin
            if (s.ptr == `TMT_MASK_ADDR) begin
              next_s.mask = s.shift[6:0];
            end else if (s.ptr == `TMT_TEST_ADDR) begin
              next_s.testMode = s.shift[`TMT_TEST_BIT];
            end
          end else if (sclFall) begin
            next_s.sdaOe = 1'b0;
            next_s.ptr = s.ptr + 8'h01;
            next_s.phase = tmt_pkg::ST_WDATA;
          end
        end
        // Address ack, or the host's answer after a read byte
        tmt_pkg::ST_ADDR_ACK, tmt_pkg::ST_RDATA_ACK: begin
          if (sclRise && s.phase == tmt_pkg::ST_RDATA_ACK) begin
            next_s.nack = sdaIn;
          end else if (sclFall) begin
            if (s.phase == tmt_pkg::ST_ADDR_ACK && !s.rw) begin
              next_s.sdaOe = 1'b0;
              next_s.phase = tmt_pkg::ST_PTR;
            end else if (s.phase == tmt_pkg::ST_RDATA_ACK && s.nack) begin
              // Host declined more data: let go of the wire
              next_s.sdaOe = 1'b0;
              next_s.phase = tmt_pkg::ST_IDLE;
            end else begin
              // Flag is captured into the byte in the same cycle it is cleared
              next_s.shift = readByte;
              next_s.sdaOe = ~readByte[7];
              next_s.bitCnt = 3'h0;
              next_s.ptr = s.ptr + 8'h01;
              next_s.phase = tmt_pkg::ST_RDATA;
              readClear = (s.ptr == `TMT_MASK_ADDR);
            end
          end
        end
        // Shift the read byte out on SCL falls so SDA only moves while SCL is low
        tmt_pkg::ST_RDATA: begin
          if (sclFall) begin
            if (s.bitCnt == 3'h7) begin
              next_s.sdaOe = 1'b0;
              next_s.phase = tmt_pkg::ST_RDATA_ACK;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.sdaOe = ~s.shift[6];
            end
            next_s.bitCnt = s.bitCnt + 3'h1;
          end
        end
        // Unused phase codes fall back to idle
        default: begin
          next_s.phase = tmt_pkg::ST_IDLE;
          next_s.sdaOe = 1'b0;
        end
      endcase
    end

    // A change in the clearing cycle still leaves the flag set
    next_s.intFlag = (|portChanged) | (next_s.intFlag & ~readClear);
  end

  // Register the copy
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.phase <= tmt_pkg::ST_IDLE;
      // Bus samples rest at the idle high level so a release cannot fake an SCL rise or a stop
      s.sclQ <= 1'b1;
      s.sdaQ <= 1'b1;
      s.mask <= `TMT_MASK_RESET;
      s.testMode <= `TMT_TEST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Open drain: the drive value stays low and only the enable moves
  assign sdaOut = 1'b0;

  // Outputs straight from state
  assign sdaOe = s.sdaOe;
  assign intPending = s.intFlag;
  assign portMask = s.mask;
  assign displayTest = s.testMode;
  assign segLevel = s.segLevel;

endmodule : tmt_regs

`default_nettype wire

/* bench/tmt_regs_sva.sv */
// Checker for tmt_regs, seeing only its ports.
// Assumes one clock domain; bound below.
`timescale 1ns/10ps
`default_nettype none
`include "tmt_defs.svh"
module tmt_regs_sva (
  input wire logic clock, // Clock
  input wire logic arst_n, // Reset
  input wire logic scl, // Serial clock
  input wire logic sdaOe, // Device pull
  input wire logic [`TMT_WATCH_PORTS-1:0] portLevel, // Ports
  input wire logic intPending, // Flag
  input wire logic [`TMT_WATCH_PORTS-1:0] portMask, // Masks
  input wire logic displayTest, // Test mode
  input wire logic [`TMT_SEGMENTS-1:0] segOn, // Enables
  input wire logic [`TMT_SEGMENTS*`TMT_CODE_W-1:0] segCode, // Codes
  input wire logic [`TMT_SEGMENTS*`TMT_LEVEL_W-1:0] segLevel // Drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [`TMT_SEGMENTS*`TMT_LEVEL_W-1:0] expLevel;
  // Commit point: device acking, SCL rose one or two samples back
  sequence ackRise;
    $past(sdaOe) && scl && (!$past(scl, 2) || !$past(scl, 3));
  endsequence
  // Expected drive, one clock behind the inputs; off reads as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      expLevel <= '0;
    end else begin
      for (int i = 0; i < `TMT_SEGMENTS; i++) begin
        expLevel[i*5 +: 5] <= segOn[i] ? {1'b0, segCode[i*4 +: 4]} + 5'h01 : 5'h00;
      end
    end
  end
  a_mask_commit: assert property ($changed(portMask) |-> ackRise) else $error("mask moved off ack");
  a_test_commit: assert property ($changed(displayTest) |-> ackRise) else $error("test moved off ack");
  a_one_target: assert property ($changed(portMask) |-> $stable(displayTest)) else $error("two targets");
  a_flag_set: assert property ($stable(portMask) && |((portLevel ^ $past(portLevel)) & portMask)
    |-> ##[1:2] intPending) else $error("flag not set");
  a_flag_clear: assert property ($fell(intPending) |-> !scl && !$past(scl)) else $error("flag clear");
  a_seg_level: assert property (segLevel == expLevel) else $error("segment drive wrong");
endmodule : tmt_regs_sva
bind tmt_regs tmt_regs_sva chk (.clock(clock), .arst_n(arst_n), .scl(scl), .sdaOe(sdaOe),
  .portLevel(portLevel), .intPending(intPending), .portMask(portMask), .displayTest(displayTest),
  .segOn(segOn), .segCode(segCode), .segLevel(segLevel));
`default_nettype wire

/* bench/tmt_host.sv */
// Serial bus host model, nine-clock bits: SCL low for five clocks, high for four.
// Assumes a pull-up resolves SDA outside.
`timescale 1ns/10ps
`default_nettype none
module tmt_host (
  input wire logic clock, // Clock
  input wire logic sda, // Wire level
  output logic scl, // Serial clock
  output logic sdaLow // Host pulls low
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Changes land 2 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  // SDA set while SCL low, sampled mid high phase
  task automatic bitIo(input logic b, output logic r);
    sdaLow = !b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask : bitIo
  task automatic startC();
    sdaLow = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sdaLow = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask : startC
  task automatic stopC();
    sdaLow = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sdaLow = 1'b0;
    tick(3);
  endtask : stopC
  // Ninth bit always released: ack seen on writes, nack given on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(1'b1, ack);
  endtask : xfer
endmodule : tmt_host
`default_nettype wire

/* bench/tb_tmt_regs.sv */
// Self-checking bench for tmt_regs with a host model.
// Assumes tmt_host and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "tmt_defs.svh"
module tb_tmt_regs;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe, intPending, displayTest, ack, f;
  logic [6:0] portLevel = '0;
  logic [6:0] portMask, m;
  logic [27:0] segOn = '0;
  logic [111:0] segCode = '0;
  logic [139:0] segLevel;
  logic [15:0] lfsr = 16'h9099;
  logic [7:0] q, d;
  int miscompares = 0;
  int num_checks = 0;
  wire sda = !(sdaOe || sdaLow); // Pulled-up wire
  always #12.5 clock = !clock;
  tmt_regs dut (.clock(clock), .arst_n(arst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .portLevel(portLevel), .intPending(intPending), .portMask(portMask), .displayTest(displayTest),
    .segOn(segOn), .segCode(segCode), .segLevel(segLevel));
  tmt_host host (.clock(clock), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic [4:0] segExp(input logic on, input logic [3:0] c);
    return on ? {1'b0, c} + 5'h01 : 5'h00;
  endfunction : segExp
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Leaves the bus open so commit is seen before stop
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.startC();
    host.xfer({`TMT_DEV_ADDR, 1'b0}, q, ack);
    host.xfer(a, q, ack);
    host.xfer(v, q, ack);
    check(8'(ack), 8'h00);
  endtask : wr
  // Pointer only, then a repeated start reads from it
  task automatic rd(input logic [7:0] a);
    host.startC();
    host.xfer({`TMT_DEV_ADDR, 1'b0}, q, ack);
    host.xfer(a, q, ack);
    host.startC();
    host.xfer({`TMT_DEV_ADDR, 1'b1}, q, ack);
    check(8'(sdaOut), 8'h00);
    host.xfer(8'hff, q, ack);
    host.stopC();
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
  initial begin
    host.tick(2);
    arst_n = 1'b1;
    check({intPending, portMask}, 8'h00);
    check(8'(displayTest), 8'h00);
    host.tick(2);
    for (int n = 0; n < 4; n++) begin
      d = (n == 0) ? 8'hff : (rnd() | 8'h80);
      wr(`TMT_MASK_ADDR, d);
      check(8'(portMask), 8'(d[6:0]));
      host.stopC();
      d = (rnd() & 8'hfe) | 8'(n[0]);
      wr(`TMT_TEST_ADDR, d);
      check(8'(displayTest), 8'(d[0]));
      host.stopC();
      rd(`TMT_TEST_ADDR);
      check(q, {7'h00, d[0]});
    end
    $display("test write_commit done");
    // Toggled ports under a random mask; only watched ones raise the flag
    for (int n = 0; n < 4; n++) begin
      d = rnd();
      m = d[6:0] | 7'h01;
      wr(`TMT_MASK_ADDR, {1'b0, m});
      host.stopC();
      d = (n == 0) ? 8'h00 : (n == 1) ? {1'b0, m} : rnd();
      portLevel = portLevel ^ d[6:0];
      f = |(d[6:0] & m);
      host.tick(12);
      check(8'(intPending), 8'(f));
      // D7 of a write carries the opposite of the flag and must not touch it
      wr(`TMT_MASK_ADDR, {~f, m});
      host.stopC();
      check(8'(intPending), 8'(f));
      rd(`TMT_MASK_ADDR);
      check(q, {f, m});
      check(8'(intPending), 8'h00);
    end
    $display("test flag done");
    // All seventeen states on segment 0, random traffic elsewhere
    for (int k = 0; k < 17; k++) begin
      segOn = {segOn[19:0], rnd()};
      segOn[0] = (k != 0);
      segCode = {segCode[103:0], rnd()};
      segCode[3:0] = 4'(k - 1);
      host.tick(2);
      check(8'(segLevel[4:0]), 8'(k));
      check(8'(segLevel[139:135]), 8'(segExp(segOn[27], segCode[111:108])));
    end
    $display("test segment done");
    // Mid-run reset clears the mask and test mode, then the bus works again
    arst_n = 1'b0;
    host.tick(2);
    check({intPending, portMask}, 8'h00);
    check(8'(displayTest), 8'h00);
    arst_n = 1'b1;
    host.tick(2);
    rd(`TMT_TEST_ADDR);
    check(q, 8'h00);
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_tmt_regs
`default_nettype wire
